// ==== common/alu_pkg.sv ====
// constants, operation codes and flag layout of the 8-bit datapath
// assumes a single core clock; shared by the core and its units
// Behaviour
// - add with carry writes dest+src+carry, sets Z C N V H, one cycle
// - word add immediate adds constant to register pair, Z C N V S, two cycles
// - word subtract immediate subtracts constant from pair, Z C N V S, two cycles
// - subtract constant writes dest-imm, sets Z C N V H, one cycle
// - subtract with borrow writes dest-src-carry, sets Z C N V H, one cycle
// - subtract borrow constant writes dest-imm-carry, sets Z C N V H, one cycle
// - and with constant writes dest AND imm, sets only Z N V, one cycle
// - or with constant writes dest OR imm, sets only Z N V, one cycle
// - set mask bits ORs imm into dest, sets Z N V, one cycle
// - clear mask bits ANDs dest with 0xFF minus imm, Z N V, one cycle
// - zero sign check keeps dest unchanged, sets Z N V, one cycle
package alu_pkg;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int REG_COUNT = 32;
    localparam int REG_COUNT_MAX = 256;
    localparam int WORD_IMM_W = 6;
    localparam int FLAGS_W = 6;
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 6'h00;
    localparam logic [DATA_W-1:0] BYTE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam logic [DATA_W-1:0] SIGN_MIN = 8'h80;
    localparam logic [DATA_W-1:0] SIGN_MAX = 8'h7f;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

    typedef enum logic [4:0] {
        OP_ADD,
        OP_ADD_CARRY,
        OP_WORD_ADD_IMMEDIATE,
        OP_SUB,
        OP_SUBTRACT_CONSTANT,
        OP_SUBTRACT_WITH_BORROW,
        OP_SUBTRACT_BORROW_CONSTANT,
        OP_WORD_SUBTRACT_IMMEDIATE,
        OP_AND,
        OP_AND_WITH_CONSTANT,
        OP_OR,
        OP_OR_WITH_CONSTANT,
        OP_BITWISE_XOR,
        OP_BITWISE_INVERT,
        OP_ARITH_SIGN_INVERT,
        OP_SET_MASK_BITS,
        OP_CLEAR_MASK_BITS,
        OP_INCREMENT,
        OP_COUNT_DOWN_BY_ONE,
        OP_ZERO_SIGN_CHECK
    } op_t;

    typedef enum logic [1:0] {
        LG_AND,
        LG_OR,
        LG_XOR
    } logic_sel_t;

    typedef enum logic {
        ST_IDLE,
        ST_WORD_HI
    } state_t;
endpackage

// ==== common/alu_arith_if.sv ====
// operand and result bundle between the core and an adder unit
// assumes the user drives operands combinationally
`timescale 1ns/10ps
interface alu_arith_if #(parameter int W = 8);
    logic [W-1:0] a;
    logic [W-1:0] b;
    logic cin;
    logic sub;
    logic [W-1:0] res;
    logic cout;
    logic ovf;
    logic half;
    modport unit (input a, b, cin, sub, output res, cout, ovf, half);
    modport user (output a, b, cin, sub, input res, cout, ovf, half);
endinterface

// ==== hw/alu_addsub.sv ====
// combinational adder/subtractor with carry, half carry and overflow
// assumes W of at least 5; cout is the borrow when sub is high
`timescale 1ns/10ps
module alu_addsub #(parameter int W = 8) (
    // operands and results
    alu_arith_if.unit io
);
    logic [W:0] ext;
    logic [4:0] nib;

    if (W < 5) begin : g_chk
        $error("alu_addsub needs at least five bits");
    end

    always_comb begin
        if (io.sub) begin
            ext = {1'b0, io.a} - {1'b0, io.b} - (W+1)'(io.cin);
            nib = {1'b0, io.a[3:0]} - {1'b0, io.b[3:0]} - 5'(io.cin);
        end else begin
            ext = {1'b0, io.a} + {1'b0, io.b} + (W+1)'(io.cin);
            nib = {1'b0, io.a[3:0]} + {1'b0, io.b[3:0]} + 5'(io.cin);
        end
    end

    assign io.res = ext[W-1:0];
    assign io.cout = ext[W];
    assign io.half = nib[4];
    // signs of operands agree (add) or differ (sub) and result sign flips
    assign io.ovf = ((io.a[W-1] ^ io.b[W-1]) == io.sub)
                    && (ext[W-1] != io.a[W-1]);
endmodule

// ==== hw/alu_bitwise.sv ====
// combinational bytewise and, or, xor
// assumes the core picks the second operand
`timescale 1ns/10ps
module alu_bitwise (
    // operands
    input wire logic [alu_pkg::DATA_W-1:0] a,
    input wire logic [alu_pkg::DATA_W-1:0] b,
    input wire alu_pkg::logic_sel_t sel,
    // result
    output logic [alu_pkg::DATA_W-1:0] res
);
    always_comb begin
        case (sel)
            alu_pkg::LG_AND: res = a & b;
            alu_pkg::LG_OR: res = a | b;
            alu_pkg::LG_XOR: res = a ^ b;
            default: res = a & b;
        endcase
    end
endmodule

// ==== hw/alu_core.sv ====
// 8-bit arithmetic and logic datapath with its own register file
// assumes requests and loads synchronous to clk_sys
`timescale 1ns/10ps
module alu_core #(
    parameter int REG_COUNT = alu_pkg::REG_COUNT,
    parameter int IDX_W = $clog2(alu_pkg::REG_COUNT)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // operation request
    input wire logic op_valid,
    output logic op_ready,
    input wire alu_pkg::op_t op_code,
    input wire logic [IDX_W-1:0] dst_idx,
    input wire logic [IDX_W-1:0] source_register,
    input wire logic [alu_pkg::DATA_W-1:0] imm,
    // operation result
    output logic done,
    output logic [alu_pkg::DATA_W-1:0] result,
    output logic [alu_pkg::FLAGS_W-1:0] flags,
    // register load and peek
    input wire logic ld_en,
    input wire logic [IDX_W-1:0] ld_idx,
    input wire logic [alu_pkg::DATA_W-1:0] ld_data,
    input wire logic [IDX_W-1:0] peek_idx,
    output logic [alu_pkg::DATA_W-1:0] peek_data
);
    localparam int FC = alu_pkg::FLAG_C;
    localparam int FZ = alu_pkg::FLAG_Z;
    localparam int FN = alu_pkg::FLAG_N;
    localparam int FV = alu_pkg::FLAG_V;
    localparam int FS = alu_pkg::FLAG_S;
    localparam int FH = alu_pkg::FLAG_H;
    localparam int MSB = alu_pkg::DATA_W - 1;
    localparam int WMSB = alu_pkg::WORD_W - 1;

    if (REG_COUNT < 2 || REG_COUNT % 2 != 0
        || REG_COUNT > alu_pkg::REG_COUNT_MAX
        || IDX_W != $clog2(REG_COUNT)) begin : g_chk
        $error("alu_core register count unusable");
    end

    ////////////////////////////////////////////////////////////////////
    // state and storage

    logic [alu_pkg::DATA_W-1:0] regs_q [REG_COUNT];
    alu_pkg::state_t state_q;
    logic [alu_pkg::FLAGS_W-1:0] flags_q;
    logic [alu_pkg::FLAGS_W-1:0] flags_d;
    logic [alu_pkg::FLAGS_W-1:0] wflags_d;
    logic [alu_pkg::FLAGS_W-1:0] wflags_q;
    logic [alu_pkg::DATA_W-1:0] result_q;
    logic [alu_pkg::DATA_W-1:0] res_d;
    logic [alu_pkg::DATA_W-1:0] hi_byte_q;
    logic [alu_pkg::DATA_W-1:0] peek_q;
    logic [IDX_W-1:0] hi_idx_q;
    logic done_q;
    logic acc;
    logic is_word;
    logic [alu_pkg::DATA_W-1:0] rd_a;
    logic [alu_pkg::DATA_W-1:0] rd_b;
    logic [alu_pkg::DATA_W-1:0] rd_hi;
    logic [alu_pkg::DATA_W-1:0] lg_b;
    logic [alu_pkg::DATA_W-1:0] lg_res;
    alu_pkg::logic_sel_t lg_sel;

    alu_arith_if #(.W(alu_pkg::DATA_W)) a8 ();
    alu_arith_if #(.W(alu_pkg::WORD_W)) w16 ();

    assign rd_a = regs_q[dst_idx];
    assign rd_b = regs_q[source_register];
    assign rd_hi = regs_q[IDX_W'(dst_idx + 1'b1)];
    assign op_ready = (state_q == alu_pkg::ST_IDLE);
    assign acc = op_valid && op_ready;
    assign is_word = (op_code == alu_pkg::OP_WORD_ADD_IMMEDIATE)
                     || (op_code == alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE);
    assign done = done_q;
    assign result = result_q;
    assign flags = flags_q;
    assign peek_data = peek_q;

    ////////////////////////////////////////////////////////////////////
    // operand steering

    always_comb begin
        a8.a = rd_a;
        a8.b = rd_b;
        a8.cin = 1'b0;
        a8.sub = 1'b0;
        case (op_code)
            alu_pkg::OP_ADD_CARRY: a8.cin = flags_q[FC];
            alu_pkg::OP_SUB: a8.sub = 1'b1;
            alu_pkg::OP_SUBTRACT_CONSTANT: begin
                a8.b = imm;
                a8.sub = 1'b1;
            end
            alu_pkg::OP_SUBTRACT_WITH_BORROW: begin
                a8.sub = 1'b1;
                a8.cin = flags_q[FC];
            end
            alu_pkg::OP_SUBTRACT_BORROW_CONSTANT: begin
                a8.b = imm;
                a8.sub = 1'b1;
                a8.cin = flags_q[FC];
            end
            alu_pkg::OP_ARITH_SIGN_INVERT: begin
                a8.a = alu_pkg::ZERO_BYTE;
                a8.b = rd_a;
                a8.sub = 1'b1;
            end
            alu_pkg::OP_INCREMENT: a8.b = alu_pkg::ONE_BYTE;
            alu_pkg::OP_COUNT_DOWN_BY_ONE: begin
                a8.b = alu_pkg::ONE_BYTE;
                a8.sub = 1'b1;
            end
            default: ;
        endcase
    end

    // register pair plus or minus zero-extended small constant
    assign w16.a = {rd_hi, rd_a};
    assign w16.b = alu_pkg::WORD_W'(imm[alu_pkg::WORD_IMM_W-1:0]);
    assign w16.cin = 1'b0;
    assign w16.sub = (op_code == alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE);

    always_comb begin
        lg_sel = alu_pkg::LG_AND;
        lg_b = rd_b;
        case (op_code)
            alu_pkg::OP_AND_WITH_CONSTANT: lg_b = imm;
            alu_pkg::OP_OR: lg_sel = alu_pkg::LG_OR;
            alu_pkg::OP_OR_WITH_CONSTANT: begin
                lg_sel = alu_pkg::LG_OR;
                lg_b = imm;
            end
            alu_pkg::OP_SET_MASK_BITS: begin
                lg_sel = alu_pkg::LG_OR;
                lg_b = imm;
            end
            alu_pkg::OP_CLEAR_MASK_BITS: lg_b = alu_pkg::ALL_ONES - imm;
            alu_pkg::OP_BITWISE_XOR: lg_sel = alu_pkg::LG_XOR;
            alu_pkg::OP_ZERO_SIGN_CHECK: lg_b = rd_a;
            default: ;
        endcase
    end

    alu_addsub #(.W(alu_pkg::DATA_W)) u_add8 (.io(a8.unit));
    alu_addsub #(.W(alu_pkg::WORD_W)) u_add16 (.io(w16.unit));
    alu_bitwise u_logic (
        .a(rd_a),
        .b(lg_b),
        .sel(lg_sel),
        .res(lg_res)
    );

    ////////////////////////////////////////////////////////////////////
    // result and flag selection

    always_comb begin
        res_d = a8.res;
        flags_d = flags_q;
        case (op_code)
            alu_pkg::OP_ADD, alu_pkg::OP_ADD_CARRY, alu_pkg::OP_SUB,
            alu_pkg::OP_SUBTRACT_CONSTANT, alu_pkg::OP_SUBTRACT_WITH_BORROW,
            alu_pkg::OP_SUBTRACT_BORROW_CONSTANT,
            alu_pkg::OP_ARITH_SIGN_INVERT: begin
                flags_d[FZ] = (a8.res == alu_pkg::ZERO_BYTE);
                flags_d[FC] = a8.cout;
                flags_d[FN] = a8.res[MSB];
                flags_d[FV] = a8.ovf;
                flags_d[FH] = a8.half;
            end
            alu_pkg::OP_AND, alu_pkg::OP_AND_WITH_CONSTANT, alu_pkg::OP_OR,
            alu_pkg::OP_OR_WITH_CONSTANT, alu_pkg::OP_BITWISE_XOR,
            alu_pkg::OP_SET_MASK_BITS, alu_pkg::OP_CLEAR_MASK_BITS,
            alu_pkg::OP_ZERO_SIGN_CHECK: begin
                res_d = lg_res;
                flags_d[FZ] = (lg_res == alu_pkg::ZERO_BYTE);
                flags_d[FN] = lg_res[MSB];
                flags_d[FV] = 1'b0;
            end
            alu_pkg::OP_BITWISE_INVERT: begin
                res_d = alu_pkg::ALL_ONES - rd_a;
                flags_d[FZ] = (rd_a == alu_pkg::ALL_ONES);
                flags_d[FC] = 1'b1;
                flags_d[FN] = ~rd_a[MSB];
                flags_d[FV] = 1'b0;
            end
            alu_pkg::OP_INCREMENT, alu_pkg::OP_COUNT_DOWN_BY_ONE: begin
                flags_d[FZ] = (a8.res == alu_pkg::ZERO_BYTE);
                flags_d[FN] = a8.res[MSB];
                flags_d[FV] = (op_code == alu_pkg::OP_INCREMENT)
                              ? (a8.res == alu_pkg::SIGN_MIN)
                              : (a8.res == alu_pkg::SIGN_MAX);
            end
            default: ;
        endcase
    end

    // word flags, applied with the high byte
    always_comb begin
        wflags_d = flags_q;
        wflags_d[FZ] = (w16.res == alu_pkg::ZERO_WORD);
        wflags_d[FC] = w16.cout;
        wflags_d[FN] = w16.res[WMSB];
        wflags_d[FV] = w16.ovf;
        wflags_d[FS] = w16.res[WMSB] ^ w16.ovf;
    end

    ////////////////////////////////////////////////////////////////////
    // sequencing

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= alu_pkg::ST_IDLE;
        end else begin
            case (state_q)
                alu_pkg::ST_IDLE: begin
                    if (acc && is_word) begin
                        state_q <= alu_pkg::ST_WORD_HI;
                    end
                end
                alu_pkg::ST_WORD_HI: state_q <= alu_pkg::ST_IDLE;
                default: state_q <= alu_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            hi_idx_q <= '0;
            hi_byte_q <= alu_pkg::BYTE_RESET;
            wflags_q <= alu_pkg::FLAGS_RESET;
        end else if (acc && is_word) begin
            hi_idx_q <= IDX_W'(dst_idx + 1'b1);
            hi_byte_q <= w16.res[WMSB:alu_pkg::DATA_W];
            wflags_q <= wflags_d;
        end
    end

    // register file: a pending high byte wins, then an operation, then a load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                regs_q[i] <= alu_pkg::BYTE_RESET;
            end
        end else if (state_q == alu_pkg::ST_WORD_HI) begin
            regs_q[hi_idx_q] <= hi_byte_q;
        end else if (acc) begin
            regs_q[dst_idx] <= is_word ? w16.res[MSB:0] : res_d;
        end else if (ld_en) begin
            regs_q[ld_idx] <= ld_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            result_q <= alu_pkg::BYTE_RESET;
            flags_q <= alu_pkg::FLAGS_RESET;
        end else if (state_q == alu_pkg::ST_WORD_HI) begin
            done_q <= 1'b1;
            result_q <= hi_byte_q;
            flags_q <= wflags_q;
        end else if (acc) begin
            done_q <= !is_word;
            result_q <= is_word ? w16.res[MSB:0] : res_d;
            flags_q <= is_word ? flags_q : flags_d;
        end else begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            peek_q <= alu_pkg::BYTE_RESET;
        end else begin
            peek_q <= regs_q[peek_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence word_start;
        acc && is_word;
    endsequence

    sequence word_finish;
        !op_ready && !done ##1 done && op_ready;
    endsequence

    adc_sum_a: assert property (
        acc && op_code == alu_pkg::OP_ADD_CARRY |=> done
        && result == $past(8'(rd_a + rd_b + 8'(flags_q[FC]))))
        else $error("add with carry result wrong");

    word_cycles_a: assert property (
        word_start |=> word_finish)
        else $error("word operation not two cycles");

    word_flags_a: assert property (
        word_start |-> ##2 flags[FS] == (flags[FN] ^ flags[FV])
        && flags[FZ] == ($past(w16.res, 2) == alu_pkg::ZERO_WORD)
        && result == $past(w16.res[WMSB:alu_pkg::DATA_W], 2))
        else $error("word operation flags wrong");

    subtract_constant_result_a: assert property (
        acc && op_code == alu_pkg::OP_SUBTRACT_CONSTANT |=> done
        && result == $past(8'(rd_a - imm))
        && flags[FC] == $past(imm > rd_a))
        else $error("subtract constant wrong");

    sbc_result_a: assert property (
        acc && op_code == alu_pkg::OP_SUBTRACT_WITH_BORROW |=>
        result == $past(8'(rd_a - rd_b - 8'(flags_q[FC]))))
        else $error("subtract with borrow wrong");

    subtract_borrow_constant_result_a: assert property (
        acc && op_code == alu_pkg::OP_SUBTRACT_BORROW_CONSTANT |=>
        result == $past(8'(rd_a - imm - 8'(flags_q[FC]))))
        else $error("subtract borrow constant wrong");

    and_with_constant_flags_a: assert property (
        acc && op_code == alu_pkg::OP_AND_WITH_CONSTANT |=>
        result == $past(rd_a & imm) && !flags[FV]
        && flags[FC] == $past(flags_q[FC]))
        else $error("and with constant wrong");

    ori_flags_a: assert property (
        acc && op_code == alu_pkg::OP_OR_WITH_CONSTANT |=>
        result == $past(rd_a | imm) && flags[FN] == result[MSB]
        && flags[FH] == $past(flags_q[FH]))
        else $error("or with constant wrong");

    set_mask_a: assert property (
        acc && op_code == alu_pkg::OP_SET_MASK_BITS |=>
        (result & $past(imm)) == $past(imm))
        else $error("set mask bits wrong");

    clear_mask_a: assert property (
        acc && op_code == alu_pkg::OP_CLEAR_MASK_BITS |=>
        (result & $past(imm)) == alu_pkg::ZERO_BYTE
        && flags[FZ] == (result == alu_pkg::ZERO_BYTE))
        else $error("clear mask bits wrong");

    zero_check_a: assert property (
        acc && op_code == alu_pkg::OP_ZERO_SIGN_CHECK |=>
        result == $past(rd_a) && !flags[FV])
        else $error("zero sign check changed value");

    xor_flags_a: assert property (
        acc && op_code == alu_pkg::OP_BITWISE_XOR |=>
        result == $past(rd_a ^ rd_b)
        && flags[FC] == $past(flags_q[FC]))
        else $error("xor result or carry wrong");

    invert_carry_a: assert property (
        acc && op_code == alu_pkg::OP_BITWISE_INVERT |=>
        flags[FC] && result == $past(~rd_a))
        else $error("invert result wrong");

    count_keep_a: assert property (
        acc && op_code == alu_pkg::OP_COUNT_DOWN_BY_ONE |=>
        flags[FC] == $past(flags_q[FC])
        && flags[FV] == ($past(rd_a) == alu_pkg::SIGN_MIN))
        else $error("count down flags wrong");
endmodule

// ==== test/test_alu_arith_logic_ops.sv ====
// self-checking bench for the 8-bit arithmetic and logic datapath
// assumes alu_core with 32 registers; inputs change on falling edges
`timescale 1ns/10ps
module test_alu_arith_logic_ops;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic op_valid = 1'b0;
    logic op_ready;
    alu_pkg::op_t op_code = alu_pkg::OP_ADD;
    logic [4:0] dst_idx = 5'h00;
    logic [4:0] source_register = 5'h00;
    logic [7:0] imm = 8'h00;
    logic done;
    logic [7:0] result;
    logic [5:0] flags;
    logic ld_en = 1'b0;
    logic [4:0] ld_idx = 5'h00;
    logic [7:0] ld_data = 8'h00;
    logic [4:0] peek_idx = 5'h00;
    logic [7:0] peek_data;
    logic [7:0] rm [32];
    logic [5:0] fm;
    logic [7:0] er;
    int error_cnt = 0;
    int comparisons = 0;

    always #2.5 clk_sys = ~clk_sys;

    alu_core u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
        .op_ready(op_ready), .op_code(op_code), .dst_idx(dst_idx),
        .source_register(source_register), .imm(imm), .done(done),
        .result(result), .flags(flags), .ld_en(ld_en), .ld_idx(ld_idx),
        .ld_data(ld_data), .peek_idx(peek_idx), .peek_data(peek_data)
    );

    ////////////////////////////////////////////////////////////
    task automatic check_byte(input logic [7:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_flags(input logic [5:0] got, exp);
        check_byte({2'b00, got}, {2'b00, exp});
    endtask

    task automatic check_bit(input logic got, exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // reference: {marker, half, overflow, carry or borrow, byte}
    function automatic logic [11:0] arith(input logic [7:0] a, b,
                                          input logic ci, sub);
        logic [7:0] bb;
        logic [8:0] s;
        logic [4:0] n;
        logic c0;
        bb = sub ? ~b : b;
        c0 = sub ? ~ci : ci;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, c0};
        n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, c0};
        return {1'b1, n[4] ^ sub, (a[7] == bb[7]) && (s[7] != a[7]),
                s[8] ^ sub, s[7:0]};
    endfunction

    task automatic predict(input alu_pkg::op_t op, input logic [4:0] d, s,
                           input logic [7:0] k);
        logic [7:0] a;
        logic [7:0] b;
        logic [11:0] x;
        logic c;
        a = rm[d];
        b = rm[s];
        c = fm[alu_pkg::FLAG_C];
        case (op)
            alu_pkg::OP_ADD: x = arith(a, b, 1'b0, 1'b0);
            alu_pkg::OP_ADD_CARRY: x = arith(a, b, c, 1'b0);
            alu_pkg::OP_SUB: x = arith(a, b, 1'b0, 1'b1);
            alu_pkg::OP_SUBTRACT_CONSTANT: x = arith(a, k, 1'b0, 1'b1);
            alu_pkg::OP_SUBTRACT_WITH_BORROW: x = arith(a, b, c, 1'b1);
            alu_pkg::OP_SUBTRACT_BORROW_CONSTANT: x = arith(a, k, c, 1'b1);
            alu_pkg::OP_ARITH_SIGN_INVERT: x = arith(8'h00, a, 1'b0, 1'b1);
            alu_pkg::OP_AND: x = {4'h0, a & b};
            alu_pkg::OP_AND_WITH_CONSTANT: x = {4'h0, a & k};
            alu_pkg::OP_OR: x = {4'h0, a | b};
            alu_pkg::OP_OR_WITH_CONSTANT: x = {4'h0, a | k};
            alu_pkg::OP_SET_MASK_BITS: x = {4'h0, a | k};
            alu_pkg::OP_BITWISE_XOR: x = {4'h0, a ^ b};
            alu_pkg::OP_CLEAR_MASK_BITS: x = {4'h0, a & (8'hff - k)};
            alu_pkg::OP_BITWISE_INVERT: x = {4'h0, 8'hff - a};
            alu_pkg::OP_INCREMENT: x = {4'h0, a + 8'h01};
            alu_pkg::OP_COUNT_DOWN_BY_ONE: x = {4'h0, a - 8'h01};
            default: x = {4'h0, a & a};
        endcase
        if (x[11]) begin
            fm[alu_pkg::FLAG_C] = x[8];
            fm[alu_pkg::FLAG_V] = x[9];
            fm[alu_pkg::FLAG_H] = x[10];
        end else if (op == alu_pkg::OP_INCREMENT) begin
            fm[alu_pkg::FLAG_V] = (x[7:0] == 8'h80);
        end else if (op == alu_pkg::OP_COUNT_DOWN_BY_ONE) begin
            fm[alu_pkg::FLAG_V] = (x[7:0] == 8'h7f);
        end else begin
            fm[alu_pkg::FLAG_V] = 1'b0;
        end
        fm[alu_pkg::FLAG_C] |= (op == alu_pkg::OP_BITWISE_INVERT);
        fm[alu_pkg::FLAG_Z] = (x[7:0] == 8'h00);
        fm[alu_pkg::FLAG_N] = x[7];
        rm[d] = x[7:0];
        er = x[7:0];
    endtask

    ////////////////////////////////////////////////////////////
    task automatic load(input logic [4:0] i, input logic [7:0] v);
        @(negedge clk_sys);
        ld_en = 1'b1;
        ld_idx = i;
        ld_data = v;
        rm[i] = v;
        @(negedge clk_sys);
        ld_en = 1'b0;
    endtask

    task automatic issue(input alu_pkg::op_t op, input logic [4:0] d, s,
                         input logic [7:0] k);
        @(negedge clk_sys);
        op_valid = 1'b1;
        op_code = op;
        dst_idx = d;
        source_register = s;
        imm = k;
        peek_idx = d;
        @(negedge clk_sys);
        op_valid = 1'b0;
    endtask

    task automatic do_op(input alu_pkg::op_t op, input logic [4:0] d, s,
                         input logic [7:0] k);
        predict(op, d, s, k);
        issue(op, d, s, k);
        check_bit(done, 1'b1);
        check_byte(result, er);
        check_flags(flags, fm);
        @(negedge clk_sys);
        check_bit(done, 1'b0);
        check_byte(peek_data, er);
    endtask

    // word pair: low byte lands first, high byte and flags one edge later
    task automatic do_word(input logic sub, input logic [4:0] d,
                           input logic [7:0] k);
        logic [4:0] h;
        logic [16:0] w;
        logic [16:0] r;
        h = d + 5'h01;
        w = {1'b0, rm[h], rm[d]};
        r = sub ? w - {11'h000, k[5:0]} : w + {11'h000, k[5:0]};
        fm[alu_pkg::FLAG_C] = r[16];
        fm[alu_pkg::FLAG_V] = sub ? (w[15] & ~r[15]) : (~w[15] & r[15]);
        fm[alu_pkg::FLAG_N] = r[15];
        fm[alu_pkg::FLAG_Z] = (r[15:0] == 16'h0000);
        fm[alu_pkg::FLAG_S] = r[15] ^ fm[alu_pkg::FLAG_V];
        rm[d] = r[7:0];
        rm[h] = r[15:8];
        issue(sub ? alu_pkg::OP_WORD_SUBTRACT_IMMEDIATE
                  : alu_pkg::OP_WORD_ADD_IMMEDIATE, d, 5'h00, k);
        check_bit(op_ready, 1'b0);
        check_bit(done, 1'b0);
        check_byte(result, r[7:0]);
        @(negedge clk_sys);
        check_bit(done, 1'b1);
        check_bit(op_ready, 1'b1);
        check_byte(result, r[15:8]);
        check_flags(flags, fm);
        check_byte(peek_data, r[7:0]);
        peek_idx = h;
        @(negedge clk_sys);
        check_byte(peek_data, r[15:8]);
    endtask

    ////////////////////////////////////////////////////////////
    task automatic sc_add();
        load(5'h01, 8'h7f);
        load(5'h02, 8'h01);
        load(5'h03, 8'hff);
        do_op(alu_pkg::OP_ADD, 5'h01, 5'h02, 8'h00);
        do_op(alu_pkg::OP_ADD, 5'h03, 5'h02, 8'h00);
        do_op(alu_pkg::OP_ADD_CARRY, 5'h02, 5'h02, 8'h00);
        do_op(alu_pkg::OP_ADD_CARRY, 5'h01, 5'h01, 8'h00);
    endtask

    task automatic sc_sub();
        load(5'h05, 8'h00);
        load(5'h06, 8'h80);
        do_op(alu_pkg::OP_SUB, 5'h05, 5'h02, 8'h00);
        do_op(alu_pkg::OP_SUBTRACT_WITH_BORROW, 5'h05, 5'h02, 8'h00);
        do_op(alu_pkg::OP_SUBTRACT_WITH_BORROW, 5'h06, 5'h02, 8'h00);
        do_op(alu_pkg::OP_SUBTRACT_CONSTANT, 5'h06, 5'h00, 8'h7e);
        do_op(alu_pkg::OP_SUBTRACT_BORROW_CONSTANT, 5'h06, 5'h00, 8'hfe);
        do_op(alu_pkg::OP_SUBTRACT_BORROW_CONSTANT, 5'h05, 5'h00, 8'h80);
    endtask

    // carry, overflow and half carry are set before each logic operation of the loop
    task automatic sc_logic();
        alu_pkg::op_t ops [8];
        ops = '{alu_pkg::OP_AND, alu_pkg::OP_AND_WITH_CONSTANT, alu_pkg::OP_OR,
                alu_pkg::OP_OR_WITH_CONSTANT, alu_pkg::OP_BITWISE_XOR,
                alu_pkg::OP_SET_MASK_BITS, alu_pkg::OP_CLEAR_MASK_BITS,
                alu_pkg::OP_ZERO_SIGN_CHECK};
        load(5'h09, 8'h81);
        load(5'h0a, 8'h3c);
        foreach (ops[i]) begin
            load(5'h08, 8'h70);
            do_op(alu_pkg::OP_SUB, 5'h08, 5'h09, 8'h00);
            do_op(ops[i], 5'h08, 5'h0a, 8'h5a);
        end
        do_op(alu_pkg::OP_ZERO_SIGN_CHECK, 5'h0b, 5'h00, 8'h00);
        do_op(alu_pkg::OP_BITWISE_XOR, 5'h0a, 5'h0a, 8'h00);
    endtask

    task automatic sc_unary();
        alu_pkg::op_t ops [4];
        logic [7:0] vals [5];
        ops = '{alu_pkg::OP_BITWISE_INVERT, alu_pkg::OP_INCREMENT,
                alu_pkg::OP_ARITH_SIGN_INVERT, alu_pkg::OP_COUNT_DOWN_BY_ONE};
        vals = '{8'h7f, 8'h80, 8'hff, 8'h01, 8'h00};
        foreach (ops[i]) begin
            foreach (vals[j]) begin
                load(5'h0c, vals[j]);
                do_op(ops[i], 5'h0c, 5'h00, 8'h00);
            end
        end
    endtask

    task automatic sc_word();
        load(5'h18, 8'hff);
        load(5'h19, 8'h7f);
        load(5'h1a, 8'hff);
        load(5'h1b, 8'hff);
        load(5'h1f, 8'hfe);
        load(5'h00, 8'h01);
        do_word(1'b0, 5'h18, 8'h01);
        do_word(1'b0, 5'h1a, 8'hc1);
        do_word(1'b1, 5'h1a, 8'h3f);
        do_word(1'b1, 5'h18, 8'h01);
        do_word(1'b0, 5'h1f, 8'h05);
    endtask

    initial begin
        foreach (rm[i]) rm[i] = 8'h00;
        fm = 6'h00;
        repeat (5) @(negedge clk_sys);
        check_bit(op_ready, 1'b1);
        check_bit(done, 1'b0);
        check_byte(result, 8'h00);
        check_flags(flags, 6'h00);
        check_byte(peek_data, 8'h00);
        rst_n = 1'b1;
        sc_add();
        sc_sub();
        sc_logic();
        sc_unary();
        sc_word();
        print_verdict();
    end
endmodule
